// ===== src/lic_pkg.sv
// package: constants and types shared by the level interrupt controller
package lic_pkg;

   // ****************************************************************
   // register addresses in the register file
   // ****************************************************************
   localparam logic [7:0] ADDR_LEVEL_REQUEST = 8'h00_DC; // read only
   localparam logic [7:0] ADDR_LEVEL_MASK = 8'h00_DD;
   localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h00_DE;
   localparam logic [7:0] ADDR_LEVEL_PRIORITY = 8'h00_FF;

   // ****************************************************************
   // system mode register fields
   // ****************************************************************
   localparam int SYM_GLOBAL_ENABLE_POS = 0; // global_enable_bit
   localparam int SYM_FAST_ENABLE_POS = 1; // fast_service_enable
   localparam int SYM_FAST_SEL_LSB = 2; // fast_level_select low bit
   localparam int SYM_FAST_SEL_MSB = 4; // fast_level_select high bit
   localparam int SYM_WIDTH = 5; // bits 7..5 read as zero

   // ****************************************************************
   // level priority register fields
   // ****************************************************************
   localparam int PRI_GROUP_A_ORDER_POS = 0; // group_a_order_bit
   localparam int PRI_GROUP_SEL_LOW_POS = 1; // group_order_select, low
   localparam int PRI_GROUP_B_ORDER_POS = 2;
   localparam int PRI_SUBGROUP_B_ORDER_POS = 3;
   localparam int PRI_GROUP_SEL_MID_POS = 4; // group_order_select, mid
   localparam int PRI_GROUP_C_ORDER_POS = 5; // group_c_order_bit
   localparam int PRI_SUBGROUP_C_ORDER_POS = 6; // subgroup_c_order_bit
   localparam int PRI_GROUP_SEL_HIGH_POS = 7; // group_order_select, high

   // ****************************************************************
   // reset values (mask, priority and fast select are undetermined;
   // zero is one legal value of undetermined)
   // ****************************************************************
   localparam logic [4:0] RST_SYSTEM_MODE = 5'h0_0;
   localparam logic [7:0] RST_LEVEL_MASK = 8'h00_00;
   localparam logic [7:0] RST_LEVEL_PRIORITY = 8'h00_00;
   localparam logic [7:0] RST_LEVEL_REQUEST = 8'h00_00;
   localparam logic [15:0] RESET_PC = 16'h0100; // program start address

   // ****************************************************************
   // sources and their vectors, all inside the first 256 bytes
   // ****************************************************************
   localparam int NUM_SOURCES = 5;
   localparam int NUM_LEVELS = 8;
   localparam logic [7:0] VEC_EXT0 = 8'h00_FC; // port pin interrupt 0
   localparam logic [7:0] VEC_EXT1 = 8'h00_FA; // port pin interrupt 1
   localparam logic [7:0] VEC_TIMER_A = 8'h00_F6; // timer A match
   localparam logic [7:0] VEC_TIMER_B = 8'h00_F4; // timer B match
   localparam logic [7:0] VEC_PWM = 8'h00_F2; // pwm overflow
   localparam logic [7:0] VEC_NONE = 8'h00_00;

   // group_order_select codes
   localparam logic [2:0] GRP_B_C_A = 3'h1;
   localparam logic [2:0] GRP_A_B_C = 3'h2;
   localparam logic [2:0] GRP_B_A_C = 3'h3;
   localparam logic [2:0] GRP_C_A_B = 3'h4;
   localparam logic [2:0] GRP_C_B_A = 3'h5;
   localparam logic [2:0] GRP_A_C_B = 3'h6;

   // service state: idle, or between acceptance and return
   typedef enum logic [0:0] {SVC_IDLE, SVC_BUSY} lic_svc_e;

endpackage

// ===== src/lic_group_pick.sv
// file: ranks up to three levels of one priority group
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// req[0] is the head level, req[2:1] form the subgroup
// headLast=0: head beats the subgroup; subOrder=0: req[1] beats req[2]
// ****************************************************************
module lic_group_pick (
   input wire logic [2:0] req,
   input wire logic headLast,
   input wire logic subOrder,
   output logic [2:0] win
);
   logic [2:0] subWin; // winner inside the subgroup

   // subgroup ranking first, then head against subgroup
   always_comb begin
      subWin = 3'h0;
      if (!subOrder) begin
         subWin[1] = req[1];
         subWin[2] = req[2] & ~req[1];
      end else begin
         subWin[2] = req[2];
         subWin[1] = req[1] & ~req[2];
      end
      if (!headLast) begin
         win = req[0] ? 3'h1 : subWin;
      end else begin
         win = (|req[2:1]) ? subWin : {2'h0, req[0]};
      end
   end

endmodule
`default_nettype wire

// ===== src/lic_controller.sv
// file: system level interrupt controller with priority and masking
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - all vectors sit in bytes 0..255
// - execution starts at address 0100H after reset
// - enable instruction sets, disable clears global enable
// - software may write global enable bit directly
// - reset clears system mode bits 1 and 0
// - mask bit n gates level n, readable
// - mask register reset value is undetermined
// - priority register reset value is undetermined
// - highest programmed priority level served first
// - same level: lower vector address wins
// - groups A(0,1), B(2,3,4), C(5,6,7)
// - bits 7,4,1 order the three groups
// - bit 5 orders group C, bit 6 subgroup
// - bit 0 orders levels 0 and 1
// - request register is read only, per level
// - global, mask and source enable all gate; priority only orders
// - pins to level 0, timers 1, pwm 2
// - request bit n shows level n, reset clears
// - acceptance clears global enable, return sets it
// - acceptance only at instruction cycle end
// - fast service selects one level, bit 1 enables
module lic_controller
   import lic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   // register file access from the core
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // instruction strobes from the core decoder
   input wire logic globalEnableInstr,
   input wire logic globalDisableInstr,
   input wire logic returnFromService,
   input wire logic instrEnd,
   // peripheral sources: pending and enable bits
   input wire logic [lic_pkg::NUM_SOURCES-1:0] srcPending,
   input wire logic [lic_pkg::NUM_SOURCES-1:0] srcEnable,
   // towards the core
   output logic intTake,
   output logic [15:0] intVector,
   output logic [2:0] intLevel,
   output logic intFast,
   output logic inService,
   output logic globalEnable,
   output logic [7:0] levelStatus,
   output logic [15:0] resetPc
);
   import lic_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [SYM_WIDTH-1:0] system_mode; // system mode bits 4..0
      logic [7:0] mask; // level mask
      logic [7:0] prio; // level priority
      logic [7:0] req; // per level request status
      logic take; // acceptance pulse
      logic [7:0] vec; // vector of the accepted source
      logic [2:0] lvl; // level of the accepted source
      logic fast; // accepted level is the fast one
      logic [7:0] rdata; // register read data
      lic_svc_e svc; // service state
   } lic_state_s;

   lic_state_s st_r; // registered state
   lic_state_s st_nxt; // next state

   // ****************************************************************
   // priority logic
   // ****************************************************************
   logic [NUM_SOURCES-1:0] srcActive; // pending and enabled at the source
   logic [NUM_LEVELS-1:0] levelRaw; // per level request from sources
   logic [NUM_LEVELS-1:0] eligible; // requests passing global and mask
   logic [2:0] winA; // group A winner, one hot over levels 0,1
   logic [2:0] winB; // group B winner over levels 2,3,4
   logic [2:0] winC; // group C winner over levels 5,6,7
   logic [2:0] grpSel; // group_order_select
   logic [NUM_LEVELS-1:0] levelWin; // one hot overall winner
   logic [2:0] winLevel; // number of the winning level
   logic [7:0] winVec; // vector of the winning source

   // a source requests only while its own enable bit is set
   assign srcActive = srcPending & srcEnable;

   // fixed routing of sources to levels; levels 3..7 carry nothing
   always_comb begin
      levelRaw = 8'h00;
      levelRaw[0] = srcActive[0] | srcActive[1];
      levelRaw[1] = srcActive[2] | srcActive[3];
      levelRaw[2] = srcActive[4];
   end

   // global enable and mask gate every level
   assign eligible = st_r.req & st_r.mask & {NUM_LEVELS{st_r.system_mode[SYM_GLOBAL_ENABLE_POS]}};

   // group A: only levels 0 and 1, bit 0 decides between them
   lic_group_pick pickA (
      .req({1'b0, eligible[1], eligible[0]}),
      .headLast(st_r.prio[PRI_GROUP_A_ORDER_POS]),
      .subOrder(1'b0),
      .win(winA)
   );

   // group B: level 2 against subgroup 3,4
   lic_group_pick pickB (
      .req(eligible[4:2]),
      .headLast(st_r.prio[PRI_GROUP_B_ORDER_POS]),
      .subOrder(st_r.prio[PRI_SUBGROUP_B_ORDER_POS]),
      .win(winB)
   );

   // group C: level 5 against subgroup 6,7
   lic_group_pick pickC (
      .req(eligible[7:5]),
      .headLast(st_r.prio[PRI_GROUP_C_ORDER_POS]),
      .subOrder(st_r.prio[PRI_SUBGROUP_C_ORDER_POS]),
      .win(winC)
   );

   assign grpSel = {st_r.prio[PRI_GROUP_SEL_HIGH_POS], st_r.prio[PRI_GROUP_SEL_MID_POS],
                    st_r.prio[PRI_GROUP_SEL_LOW_POS]};

   // order the three groups; the first group with a winner takes it
   always_comb begin
      logic [7:0] wa;
      logic [7:0] wb;
      logic [7:0] wc;
      wa = {6'h00, winA[1:0]};
      wb = {3'h0, winB, 2'h0};
      wc = {winC, 5'h00};
      case (grpSel)
         GRP_B_C_A: begin
            levelWin = (|wb) ? wb : ((|wc) ? wc : wa);
         end
         GRP_C_B_A: begin
            levelWin = (|wc) ? wc : ((|wb) ? wb : wa);
         end
         GRP_B_A_C: begin
            levelWin = (|wb) ? wb : ((|wa) ? wa : wc);
         end
         GRP_C_A_B: begin
            levelWin = (|wc) ? wc : ((|wa) ? wa : wb);
         end
         GRP_A_C_B: begin
            levelWin = (|wa) ? wa : ((|wc) ? wc : wb);
         end
         default: begin
            // A over B over C, also for the two unassigned codes
            levelWin = (|wa) ? wa : ((|wb) ? wb : wc);
         end
      endcase
   end

   // level number and source vector; in a level the lower vector wins
   always_comb begin
      winLevel = 3'h0;
      winVec = VEC_NONE;
      for (int i = 0; i < NUM_LEVELS; i++) begin
         if (levelWin[i]) begin
            winLevel = 3'(i);
         end
      end
      if (levelWin[0]) begin
         winVec = srcActive[1] ? VEC_EXT1 : VEC_EXT0;
      end else if (levelWin[1]) begin
         winVec = srcActive[3] ? VEC_TIMER_B : VEC_TIMER_A;
      end else if (levelWin[2]) begin
         winVec = VEC_PWM;
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic accept;
      st_nxt = st_r;
      accept = instrEnd && (|levelWin); // only at instruction end
      // per level status follows the sources, even while disabled
      st_nxt.req = levelRaw;
      st_nxt.take = accept;
      // register writes; the request register ignores writes
      if (regWrite) begin
         case (regAddr)
            ADDR_LEVEL_MASK: begin
               st_nxt.mask = regWdata;
            end
            ADDR_SYSTEM_MODE: begin
               st_nxt.system_mode = regWdata[SYM_WIDTH-1:0]; // direct write
            end
            ADDR_LEVEL_PRIORITY: begin
               st_nxt.prio = regWdata;
            end
            default: begin
               st_nxt.system_mode = st_nxt.system_mode; // unmapped here: no effect
            end
         endcase
      end
      // instructions override a same cycle register write
      if (globalEnableInstr || returnFromService) begin
         st_nxt.system_mode[SYM_GLOBAL_ENABLE_POS] = 1'b1;
      end
      if (globalDisableInstr) begin
         st_nxt.system_mode[SYM_GLOBAL_ENABLE_POS] = 1'b0;
      end
      // acceptance closes the door to further requests
      if (accept) begin
         st_nxt.system_mode[SYM_GLOBAL_ENABLE_POS] = 1'b0;
         st_nxt.vec = winVec;
         st_nxt.lvl = winLevel;
         st_nxt.fast = st_r.system_mode[SYM_FAST_ENABLE_POS] &&
                       (st_r.system_mode[SYM_FAST_SEL_MSB:SYM_FAST_SEL_LSB] == winLevel);
      end
      // service tracking
      case (st_r.svc)
         SVC_IDLE: begin
            if (accept) begin
               st_nxt.svc = SVC_BUSY;
            end
         end
         SVC_BUSY: begin
            // a nested acceptance keeps the state busy
            if (returnFromService && !accept) begin
               st_nxt.svc = SVC_IDLE;
            end
         end
         default: begin
            st_nxt.svc = SVC_IDLE;
         end
      endcase
      // read data, one cycle after the read strobe; upper sym bits are zero
      if (regRead) begin
         case (regAddr)
            ADDR_LEVEL_REQUEST: begin
               st_nxt.rdata = st_r.req;
            end
            ADDR_LEVEL_MASK: begin
               st_nxt.rdata = st_r.mask;
            end
            ADDR_SYSTEM_MODE: begin
               st_nxt.rdata = {3'h0, st_r.system_mode};
            end
            ADDR_LEVEL_PRIORITY: begin
               st_nxt.rdata = st_r.prio;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ****************************************************************
   // registers; mask and priority take a plain zero for undetermined
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r.system_mode <= RST_SYSTEM_MODE;
         st_r.mask <= RST_LEVEL_MASK;
         st_r.prio <= RST_LEVEL_PRIORITY;
         st_r.req <= RST_LEVEL_REQUEST;
         st_r.take <= 1'b0;
         st_r.vec <= VEC_NONE;
         st_r.lvl <= 3'h0;
         st_r.fast <= 1'b0;
         st_r.rdata <= 8'h00;
         st_r.svc <= SVC_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flip-flops, except the constant resetPc
   assign regRdata = st_r.rdata;
   assign intTake = st_r.take;
   assign intVector = {8'h00, st_r.vec}; // vector area is bytes 0..255
   assign intLevel = st_r.lvl;
   assign intFast = st_r.fast;
   assign inService = (st_r.svc == SVC_BUSY);
   assign globalEnable = st_r.system_mode[SYM_GLOBAL_ENABLE_POS];
   assign levelStatus = st_r.req;
   assign resetPc = RESET_PC; // constant start address

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_take_at_end: assert property (@(posedge clk) disable iff (!rstn)
      intTake |-> $past(instrEnd))
      else $error("acceptance not at instruction end");

   chk_take_clears_ge: assert property (@(posedge clk) disable iff (!rstn)
      intTake |-> !globalEnable)
      else $error("global enable still set after acceptance");

   chk_upper_levels_idle: assert property (@(posedge clk) disable iff (!rstn)
      levelStatus[7:3] == 5'h00)
      else $error("request on a level without sources");

   chk_vector_area: assert property (@(posedge clk) disable iff (!rstn)
      intTake |-> (intVector[15:8] == 8'h00) && (intVector != 16'h0000))
      else $error("vector outside the vector area");

   chk_ei_sets: assert property (@(posedge clk) disable iff (!rstn)
      (globalEnableInstr && !globalDisableInstr && !instrEnd) |=> globalEnable)
      else $error("enable instruction did not set global enable");

   chk_di_clears: assert property (@(posedge clk) disable iff (!rstn)
      globalDisableInstr |=> !globalEnable)
      else $error("disable instruction did not clear global enable");

   chk_return_sets: assert property (@(posedge clk) disable iff (!rstn)
      (returnFromService && !globalDisableInstr && !instrEnd) |=> globalEnable ##0 !inService)
      else $error("return did not restore global enable");

   chk_off_no_take: assert property (@(posedge clk) disable iff (!rstn)
      (!globalEnable || st_r.mask == 8'h00) |=> !intTake)
      else $error("acceptance while disabled or fully masked");

   chk_mask_gates: assert property (@(posedge clk) disable iff (!rstn)
      (intTake && !$past(regWrite)) |-> (($past(st_r.mask) >> intLevel) & 8'h01) == 8'h01)
      else $error("masked level accepted");

   chk_group_order: assert property (@(posedge clk) disable iff (!rstn)
      (instrEnd && eligible[2] && eligible[0] && grpSel == GRP_B_C_A) |=>
         intTake && intLevel == 3'h2)
      else $error("group B did not beat group A");

   chk_same_level: assert property (@(posedge clk) disable iff (!rstn)
      (instrEnd && levelWin[0] && srcActive[1] && srcActive[0]) |=> intVector[7:0] == VEC_EXT1)
      else $error("higher vector won inside a level");

   chk_status_read: assert property (@(posedge clk) disable iff (!rstn)
      (regRead && regAddr == ADDR_LEVEL_REQUEST) |=> regRdata == $past(levelStatus))
      else $error("request register read mismatch");

   chk_status_follows: assert property (@(posedge clk) disable iff (!rstn)
      srcActive[4] |=> levelStatus[2])
      else $error("pwm request not on level two");

   chk_fast_flag: assert property (@(posedge clk) disable iff (!rstn)
      (intTake || $changed(intFast)) |-> intTake &&
         (intFast == ($past(st_r.system_mode[SYM_FAST_ENABLE_POS]) &&
         ($past(st_r.system_mode[SYM_FAST_SEL_MSB:SYM_FAST_SEL_LSB]) == intLevel))))
      else $error("fast flag without fast enable");

endmodule
`default_nettype wire

// ===== testbench/lic_core_model.sv
// partner model: peripheral pending bits and the core's service routine
`timescale 1ns/1ns
`default_nettype none
module lic_core_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pendLoad,
   input wire logic [4:0] pendVal,
   input wire logic [2:0] retWait,
   input wire logic intTake,
   input wire logic [15:0] intVector,
   output logic [4:0] srcPending,
   output logic returnFromService
);
   import lic_pkg::*;
   logic [2:0] cnt_r; // cycles left in the service routine
   logic busy_r; // a service routine is running
   int idx; // source that owns the accepted vector
   // ****************************************************************
   // vector back to source index
   // ****************************************************************
   always_comb begin
      case (intVector[7:0])
         VEC_EXT0: idx = 0;
         VEC_EXT1: idx = 1;
         VEC_TIMER_A: idx = 2;
         VEC_TIMER_B: idx = 3;
         default: idx = 4;
      endcase
   end
   // routine clears its pending bit first, returns retWait+1 cycles after it sees intTake
   // so both prompt and slow returns are exercised
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         srcPending <= 5'h00;
         cnt_r <= 3'h0;
         busy_r <= 1'b0;
         returnFromService <= 1'b0;
      end else begin
         returnFromService <= 1'b0;
         if (pendLoad) begin
            srcPending <= pendVal;
         end
         if (intTake) begin
            busy_r <= 1'b1;
            cnt_r <= retWait;
            srcPending[idx] <= 1'b0;
         end else if (busy_r) begin
            if (cnt_r == 3'h0) begin
               returnFromService <= 1'b1;
               busy_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 3'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/lic_controller_tb_top.sv
// testbench: random trials checked against a priority model
`timescale 1ns/1ns
`default_nettype none
module lic_controller_tb_top;
   import lic_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00_00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regWdata = 8'h00_00;
   logic geIn = 1'b0; // enable instruction strobe
   logic gdIn = 1'b0; // disable instruction strobe
   logic instrEnd = 1'b0;
   logic [4:0] srcEnable = 5'h00;
   logic pendLoad = 1'b0;
   logic [4:0] pendVal = 5'h00;
   logic [2:0] retWait = 3'h0;
   logic [7:0] regRdata, levelStatus;
   logic returnFromService, intTake, intFast, inService, globalEnable;
   logic [4:0] srcPending;
   logic [15:0] intVector, resetPc;
   logic [2:0] intLevel;
   logic [31:0] seed = 32'h0000_004F; // xorshift state
   int errors = 0;
   int total_checks = 0;
   int takes = 0; // accepted requests seen at the port
   // clock, 10 ns period
   always #5 clk = ~clk;
   // counted on the falling edge, where the pulse has settled
   always @(negedge clk) if (intTake === 1'b1) takes++;
   lic_controller i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .globalEnableInstr(geIn), .globalDisableInstr(gdIn),
      .returnFromService(returnFromService), .instrEnd(instrEnd), .srcPending(srcPending),
      .srcEnable(srcEnable), .intTake(intTake), .intVector(intVector), .intLevel(intLevel),
      .intFast(intFast), .inService(inService), .globalEnable(globalEnable),
      .levelStatus(levelStatus), .resetPc(resetPc));
   lic_core_model i_core (.clk(clk), .rstn(rstn), .pendLoad(pendLoad), .pendVal(pendVal),
      .retWait(retWait), .intTake(intTake), .intVector(intVector), .srcPending(srcPending),
      .returnFromService(returnFromService));
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one write cycle, then an idle cycle before the next request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk);
      #1;
      regRead = 1'b0;
      chk({8'h00_00, regRdata}, {8'h00_00, exp}, msg);
   endtask
   task automatic strobe(input bit en);
      @(posedge clk);
      #1;
      if (en) geIn = 1'b1;
      else gdIn = 1'b1;
      @(posedge clk);
      #1;
      geIn = 1'b0;
      gdIn = 1'b0;
   endtask
   // reference: winner among levels 0..2 by group order, then vector order
   function automatic void model(input logic [4:0] act, input logic [7:0] msk,
      input logic [7:0] pri, input bit ge, output bit tk, output logic [7:0] vec,
      output logic [2:0] lv);
      int ord[3];
      int gc;
      logic [2:0] lvl;
      lvl = {act[4], act[3] | act[2], act[1] | act[0]};
      gc = {pri[7], pri[4], pri[1]};
      if (gc == 1 || gc == 3 || gc == 5) ord = '{2, pri[0], !pri[0]};
      else ord = '{pri[0], !pri[0], 2};
      tk = 1'b0;
      lv = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (!tk && ge && lvl[ord[i]] && msk[ord[i]]) begin
            tk = 1'b1;
            lv = ord[i][2:0];
         end
      end
      case (lv)
         3'h0: vec = act[1] ? VEC_EXT1 : VEC_EXT0;
         3'h1: vec = act[3] ? VEC_TIMER_B : VEC_TIMER_A;
         default: vec = VEC_PWM;
      endcase
   endfunction
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [31:0] r;
      logic [7:0] msk, pri, system_mode, st, vec;
      logic [4:0] act;
      logic [2:0] lv;
      bit ge, tk;
      int nt;
      nt = 0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk(resetPc, 16'h0100, "reset pc");
      chk({15'h0000, globalEnable}, 16'h0000, "ge reset");
      rd(ADDR_SYSTEM_MODE, 8'h00_00, "sym reset");
      rd(ADDR_LEVEL_REQUEST, 8'h00_00, "req reset");
      for (int i = 0; i < 60; i++) begin
         strobe(1'b0); // all off before mask and source writes
         r = rnd();
         msk = r[7:0] | (i[0] ? 8'h00_07 : 8'h00_00);
         pri = r[15:8];
         system_mode = {3'h0, r[20:16]};
         ge = system_mode[0];
         wr(ADDR_LEVEL_MASK, msk);
         wr(ADDR_LEVEL_PRIORITY, pri);
         wr(ADDR_SYSTEM_MODE, system_mode);
         if (r[22:21] == 2'h1) begin
            strobe(1'b1);
            ge = 1'b1;
         end else if (r[22:21] == 2'h2) begin
            strobe(1'b0);
            ge = 1'b0;
         end
         chk({15'h0000, globalEnable}, {15'h0000, ge}, "ge");
         rd(ADDR_LEVEL_MASK, msk, "mask");
         rd(ADDR_LEVEL_PRIORITY, pri, "prio");
         rd(ADDR_SYSTEM_MODE, {3'h0, system_mode[4:1], ge}, "sym");
         rd(8'h00_80, 8'h00_00, "unmapped");
         r = rnd();
         srcEnable = r[9:5] | r[14:10];
         pendVal = r[4:0];
         retWait = r[17:15];
         act = pendVal & srcEnable;
         pendLoad = 1'b1;
         @(posedge clk);
         #1;
         pendLoad = 1'b0;
         @(posedge clk);
         #1;
         st = {5'h00, act[4], act[3] | act[2], act[1] | act[0]};
         chk({8'h00_00, levelStatus}, {8'h00_00, st}, "status");
         wr(ADDR_LEVEL_REQUEST, 8'h00_FF);
         if (i[0]) rd(ADDR_LEVEL_REQUEST, st, "req read");
         model(act, msk, pri, ge, tk, vec, lv);
         instrEnd = 1'b1;
         @(posedge clk);
         #1;
         instrEnd = 1'b0;
         chk({15'h0000, intTake}, {15'h0000, tk}, "take");
         if (tk) begin
            nt++;
            chk(intVector, {8'h00_00, vec}, "vector");
            chk({13'h0000, intLevel}, {13'h0000, lv}, "level");
            chk({15'h0000, intFast}, {15'h0000, system_mode[1] && system_mode[4:2] == lv}, "fast");
            chk({14'h0000, globalEnable, inService}, 16'h0001, "accept");
            for (int k = 0; k < 20 && inService !== 1'b0; k++) begin
               @(posedge clk);
               #1;
            end
            chk({14'h0000, globalEnable, inService}, 16'h0002, "return");
         end else begin
            chk({15'h0000, globalEnable}, {15'h0000, ge}, "no take ge");
         end
         pendVal = 5'h00;
         pendLoad = 1'b1;
         @(posedge clk);
         #1;
         pendLoad = 1'b0;
         @(posedge clk);
         #1;
      end
      chk(takes[15:0], nt[15:0], "take count");
      end_sim();
   end
   // watchdog cuts a hang short
   initial begin
      #200000;
      errors++;
      $display("CHECK FAILED %0t watchdog", $time);
      end_sim();
   end
endmodule
`default_nettype wire
